// ### rtl/acl_params.svh
// Constants for the add-with-carry and literal-AND execution block.
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH
`define ACL_OPC_ADDC         6'h08
`define ACL_OPC_ANDL         8'h0B
`define ACL_DEST_BIT         9
`define ACL_ACCESS_BIT       8
`define ACL_ILO_LIMIT        8'h5F
`define ACL_ACCESS_SPLIT     8'h60
`define ACL_ACCESS_HI_BANK   4'hF
`define ACL_FLAG_N           4
`define ACL_FLAG_OV          3
`define ACL_FLAG_Z           2
`define ACL_FLAG_DC          1
`define ACL_FLAG_C           0
`define ACL_ACC_RESET        8'h00
`define ACL_FLAGS_RESET      5'h00
`endif

// ### rtl/acl_pkg.sv
// Types shared by the execution block files.
`default_nettype none
package acl_pkg;
   typedef enum logic [1:0] {ACL_Q1, ACL_Q2, ACL_Q3, ACL_Q4} acl_phase_t;
   typedef enum logic [1:0] {ACL_OP_NONE, ACL_OP_ADDC, ACL_OP_ANDL} acl_op_t;
endpackage
`default_nettype wire

// ### rtl/acl_mem_if.sv
// Data-memory port carried between the execution core and its memory.
`default_nettype none
interface acl_mem_if;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic        we;
   logic [7:0]  rdata;
   modport core (output addr, output wdata, output we, input rdata);
   modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ### rtl/acl_ram.sv
// Small data memory with registered read data.
`default_nettype none
module acl_ram
(
   // Clock.
   input  wire logic clk_i,
   // Access port.
   acl_mem_if.mem    mem
);
   // Contents start at zero so that a first read never feeds unknown data into the sums.
   logic [7:0] store_r [0:4095] = '{default: 8'h00};
   logic [7:0] rdata_r;

   always_ff @(posedge clk_i)
   begin
      if (mem.we)
      begin
         store_r[mem.addr] <= mem.wdata;
      end
   end

   always_ff @(posedge clk_i)
   begin
      rdata_r <= store_r[mem.addr];
   end

   assign mem.rdata = rdata_r;
endmodule
`default_nettype wire

// ### rtl/acl_exec.sv
// Execution logic for the add-with-carry and literal-AND instructions.
// Function
// - Add-with-carry sums accumulator, memory byte, carry; sets N, OV, C, DC, Z.
// - Destination bit 0 writes accumulator; 1 writes memory register back.
// - Access bit 0 uses access bank; 1 takes bank from bank selector.
// - Access 0, extended set, operand at most 5Fh: indexed literal offset.
// - Literal-AND ANDs accumulator with literal into accumulator; sets N, Z only.
`include "acl_params.svh"
`default_nettype none
module acl_exec
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Instruction from fetch.
   input  wire logic [15:0] instr_i,
   input  wire logic        instr_valid_i,
   // Core context.
   input  wire logic [3:0]  bank_selector_i,
   input  wire logic        ext_set_en_i,
   input  wire logic [11:0] index_base_i,
   // Architectural state.
   output logic      [7:0]  acc_o,
   output logic      [4:0]  flags_o,
   output logic      [1:0]  phase_o,
   output logic             done_o,
   output logic             illegal_o,
   // Memory observation.
   output logic      [11:0] mem_addr_o,
   output logic      [7:0]  mem_wdata_o,
   output logic             mem_we_o
);
   acl_mem_if              mif ();
   acl_pkg::acl_phase_t    phase_r;
   acl_pkg::acl_op_t       op_r;
   logic [15:0]            ir_r;
   logic [7:0]             acc_r;
   logic [4:0]             flags_r;
   logic [7:0]             opnd_r;
   logic [7:0]             res_r;
   logic [4:0]             res_flags_r;
   logic [11:0]            addr_r;
   logic                   done_r;
   logic                   illegal_r;
   logic [7:0]             fval;
   logic [8:0]             sum9;
   logic [4:0]             sum_lo;
   logic [7:0]             and_v;
   logic [11:0]            addr_nxt;
   logic                   dest_mem;

   acl_ram u_ram
   (
      .clk_i (clk_i),
      .mem   (mif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Quarter sequencer: a new instruction is only taken at Q1.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         phase_r <= acl_pkg::ACL_Q1;
      end
      else
      begin
         case (phase_r)
            acl_pkg::ACL_Q1: phase_r <= instr_valid_i ? acl_pkg::ACL_Q2 : acl_pkg::ACL_Q1;
            acl_pkg::ACL_Q2: phase_r <= acl_pkg::ACL_Q3;
            acl_pkg::ACL_Q3: phase_r <= acl_pkg::ACL_Q4;
            acl_pkg::ACL_Q4: phase_r <= acl_pkg::ACL_Q1;
            default:         phase_r <= acl_pkg::ACL_Q1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address resolution, done combinationally from the instruction word.
   always_comb
   begin
      if (!instr_i[`ACL_ACCESS_BIT])
      begin
         if (ext_set_en_i && (instr_i[7:0] <= `ACL_ILO_LIMIT))
         begin
            addr_nxt = index_base_i + {4'h0, instr_i[7:0]};
         end
         else if (instr_i[7:0] < `ACL_ACCESS_SPLIT)
         begin
            addr_nxt = {4'h0, instr_i[7:0]};
         end
         else
         begin
            addr_nxt = {`ACL_ACCESS_HI_BANK, instr_i[7:0]};
         end
      end
      else
      begin
         addr_nxt = {bank_selector_i, instr_i[7:0]};
      end
   end

   // Decode in Q1.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         op_r      <= acl_pkg::ACL_OP_NONE;
         ir_r      <= 16'h0000;
         addr_r    <= 12'h000;
         illegal_r <= 1'b0;
      end
      else if (phase_r == acl_pkg::ACL_Q1 && instr_valid_i)
      begin
         ir_r   <= instr_i;
         addr_r <= addr_nxt;
         if (instr_i[15:10] == `ACL_OPC_ADDC)
         begin
            op_r      <= acl_pkg::ACL_OP_ADDC;
            illegal_r <= 1'b0;
         end
         else if (instr_i[15:8] == `ACL_OPC_ANDL)
         begin
            op_r      <= acl_pkg::ACL_OP_ANDL;
            illegal_r <= 1'b0;
         end
         else
         begin
            op_r      <= acl_pkg::ACL_OP_NONE;
            illegal_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read operand: the literal is latched in Q2, while the memory byte is used straight
   // from the registered read port in Q3; a Q2 capture would still hold the old address.
   assign mif.addr = addr_r;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         opnd_r <= 8'h00;
      end
      else if (phase_r == acl_pkg::ACL_Q2)
      begin
         opnd_r <= ir_r[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compute in Q3.
   assign fval   = (op_r == acl_pkg::ACL_OP_ADDC) ? mif.rdata : opnd_r;
   assign sum9   = {1'b0, acc_r} + {1'b0, fval} + {8'h00, flags_r[`ACL_FLAG_C]};
   assign sum_lo = {1'b0, acc_r[3:0]} + {1'b0, fval[3:0]} + {4'h0, flags_r[`ACL_FLAG_C]};
   assign and_v  = acc_r & fval;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_r       <= 8'h00;
         res_flags_r <= `ACL_FLAGS_RESET;
      end
      else if (phase_r == acl_pkg::ACL_Q3)
      begin
         res_flags_r <= flags_r;
         if (op_r == acl_pkg::ACL_OP_ADDC)
         begin
            res_r                    <= sum9[7:0];
            res_flags_r[`ACL_FLAG_N] <= sum9[7];
            res_flags_r[`ACL_FLAG_OV] <= (acc_r[7] == fval[7]) && (sum9[7] != acc_r[7]);
            res_flags_r[`ACL_FLAG_Z] <= (sum9[7:0] == 8'h00);
            res_flags_r[`ACL_FLAG_DC] <= sum_lo[4];
            res_flags_r[`ACL_FLAG_C] <= sum9[8];
         end
         else
         begin
            res_r                    <= and_v;
            res_flags_r[`ACL_FLAG_N] <= and_v[7];
            res_flags_r[`ACL_FLAG_Z] <= (and_v == 8'h00);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write destination in Q4.
   assign dest_mem  = (op_r == acl_pkg::ACL_OP_ADDC) && ir_r[`ACL_DEST_BIT];
   assign mif.we    = (phase_r == acl_pkg::ACL_Q4) && dest_mem;
   assign mif.wdata = res_r;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_r   <= `ACL_ACC_RESET;
         flags_r <= `ACL_FLAGS_RESET;
      end
      else if (phase_r == acl_pkg::ACL_Q4 && op_r != acl_pkg::ACL_OP_NONE)
      begin
         flags_r <= res_flags_r;
         if (!dest_mem)
         begin
            acc_r <= res_r;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= (phase_r == acl_pkg::ACL_Q4);
      end
   end

   assign acc_o       = acc_r;
   assign flags_o     = flags_r;
   assign phase_o     = phase_r;
   assign done_o      = done_r;
   assign illegal_o   = illegal_r;
   assign mem_addr_o  = addr_r;
   assign mem_wdata_o = res_r;
   assign mem_we_o    = mif.we;
endmodule
`default_nettype wire

// ### bench/acl_fetch_model.sv
// Fetch stage model that hands instruction words to the execution block.
`default_nettype none
module acl_fetch_model
(
   // Clock and stage state.
   input  wire logic        clk_i,
   input  wire logic [1:0]  phase_i,
   // Next word from the bench.
   input  wire logic [15:0] word_i,
   input  wire logic        go_i,
   // Instruction out.
   output logic      [15:0] instr_o,
   output logic             valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Outside Q1 and Q4 both lines invert every cycle, so a late sample sees junk.
   always @(posedge clk_i)
   begin
      instr_o <= (phase_i == 2'h0 || phase_i == 2'h3) ? word_i : ~instr_o;
      valid_o <= (phase_i == 2'h0 || phase_i == 2'h3) ? go_i : ~valid_o;
   end
endmodule
`default_nettype wire

// ### bench/acl_exec_sva.sv
// Assertions on the ports of the execution block.
`include "acl_params.svh"
`default_nettype none
module acl_exec_sva
(
   // Clock and reset.
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Inputs.
   input wire logic [15:0] instr_i,
   input wire logic        instr_valid_i,
   input wire logic [3:0]  bank_selector_i,
   input wire logic        ext_set_en_i,
   input wire logic [11:0] index_base_i,
   // Outputs.
   input wire logic [7:0]  acc_o,
   input wire logic [4:0]  flags_o,
   input wire logic [1:0]  phase_o,
   input wire logic        done_o,
   input wire logic [11:0] mem_addr_o,
   input wire logic        mem_we_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic tk;
   logic addc;
   logic andl;
   assign tk = phase_o == 2'h0 && instr_valid_i;
   assign addc = tk && instr_i[15:10] == `ACL_OPC_ADDC;
   assign andl = tk && instr_i[15:8] == `ACL_OPC_ANDL;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_we_in_q4: assert property (mem_we_o |-> phase_o == 2'h3)
      else $error("memory write outside Q4");
   a_phase_steps: assert property (phase_o != 2'h0 |=> phase_o == $past(phase_o) + 2'h1)
      else $error("quarter did not advance");
   a_take_starts: assert property (tk |=> phase_o == 2'h1)
      else $error("instruction not taken in Q1");
   a_done_after_q4: assert property (done_o |-> $past(phase_o) == 2'h3)
      else $error("done not after Q4");
   a_andl_result: assert property (andl |=> ##3 acc_o == ($past(acc_o, 4) & $past(instr_i, 4))
      && flags_o[4] == acc_o[7] && flags_o[2] == (acc_o == 8'h00))
      else $error("literal AND result wrong");
   a_andl_keeps: assert property (andl |=> ##3 flags_o[3] == $past(flags_o[3], 4)
      && flags_o[1:0] == $past(flags_o[1:0], 4))
      else $error("literal AND touched other flags");
   a_addc_dest: assert property (addc |=> ##2 mem_we_o == $past(instr_i[9], 3))
      else $error("write destination wrong");
   a_bank_addr: assert property (addc && instr_i[8]
      |=> mem_addr_o == {$past(bank_selector_i), $past(instr_i[7:0])})
      else $error("banked address wrong");
   a_ilo_addr: assert property (addc && !instr_i[8] && ext_set_en_i && instr_i[7:0] <= 8'h5F
      |=> mem_addr_o == $past(index_base_i) + $past(instr_i[7:0]))
      else $error("indexed address wrong");
   a_addc_zero: assert property (addc && !instr_i[9] |=> ##3 flags_o[2] == (acc_o == 8'h00))
      else $error("zero flag wrong after add");
endmodule
`default_nettype wire

// ### bench/test_add_carry_and_literal_and_exec.sv
// Self-checking bench for the execution block.
`include "acl_params.svh"
`default_nettype none
module test_add_carry_and_literal_and_exec;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, rst_i, go, ext_r, valid, done_o, illegal_o, mem_we_o;
   logic        pend, ill_m, we_m, chk_a;
   logic [15:0] word, instr, r;
   logic [3:0]  bank_r;
   logic [11:0] base_r, addr_m, mem_addr_o;
   logic [7:0]  acc_o, acc_m, res_m, mem_wdata_o;
   logic [7:0]  mem_m [0:4095];
   logic [4:0]  flags_o, flags_m;
   logic [1:0]  phase_o;
   int          num_errors, checks_done, cycles, retired;
   acl_exec DUT (.clk_i, .rst_i, .instr_i(instr), .instr_valid_i(valid),
      .bank_selector_i(bank_r), .ext_set_en_i(ext_r), .index_base_i(base_r), .acc_o, .flags_o,
      .phase_o, .done_o, .illegal_o, .mem_addr_o, .mem_wdata_o, .mem_we_o);
   acl_fetch_model u_fetch (.clk_i, .phase_i(phase_o), .word_i(word), .go_i(go),
      .instr_o(instr), .valid_o(valid));
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Reference model; memory starts at zero as in the design, so every result is predicted.
   task automatic decode(input logic [15:0] w);
      logic [7:0] f;
      int         s;
      int         sv;
      int         dc;
      pend = 1'b1;
      ill_m = 1'b0;
      we_m = 1'b0;
      chk_a = 1'b0;
      if (w[15:10] == `ACL_OPC_ADDC)
      begin
         we_m = w[`ACL_DEST_BIT];
         chk_a = 1'b1;
         addr_m = w[`ACL_ACCESS_BIT] ? {bank_r, w[7:0]} : (ext_r && w[7:0] <= `ACL_ILO_LIMIT)
            ? base_r + w[7:0] : {w[7:0] < `ACL_ACCESS_SPLIT ? 4'h0 : `ACL_ACCESS_HI_BANK, w[7:0]};
         f = mem_m[addr_m];
         s = int'(acc_m) + int'(f) + int'(flags_m[`ACL_FLAG_C]);
         sv = int'($signed(acc_m)) + int'($signed(f)) + int'(flags_m[`ACL_FLAG_C]);
         dc = int'(acc_m[3:0]) + int'(f[3:0]) + int'(flags_m[`ACL_FLAG_C]);
         res_m = 8'(s);
         flags_m[`ACL_FLAG_N] = res_m[7];
         flags_m[`ACL_FLAG_OV] = sv > 127 || sv < -128;
         flags_m[`ACL_FLAG_Z] = res_m == 8'h00;
         flags_m[`ACL_FLAG_DC] = dc > 15;
         flags_m[`ACL_FLAG_C] = s > 255;
         if (w[`ACL_DEST_BIT])
            mem_m[addr_m] = res_m;
         else
            acc_m = res_m;
      end
      else if (w[15:8] == `ACL_OPC_ANDL)
      begin
         res_m = acc_m & w[7:0];
         acc_m = res_m;
         flags_m[`ACL_FLAG_N] = res_m[7];
         flags_m[`ACL_FLAG_Z] = res_m == 8'h00;
      end
      else
         ill_m = 1'b1;
   endtask
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles > 2000)
      begin
         num_errors++;
         conclude();
      end
      if (cycles == 1)
         void'($urandom(32'hA28A9389));
      r = 16'($urandom);
      if (!rst_i && (phase_o === 2'h2 || (phase_o === 2'h0 && valid !== 1'b1)))
      begin
         word <= r[15:14] == 2'h0 ? {`ACL_OPC_ADDC, r[9:0]} : r[15:14] == 2'h1
            ? {`ACL_OPC_ANDL, r[7:0]} : r[15:14] == 2'h2 ? {`ACL_OPC_ANDL, 8'h00}
            : 16'($urandom);
         go <= r[13:11] != 3'h0;
         bank_r <= r[3:0];
         ext_r <= r[4];
         base_r <= 12'($urandom);
      end
      if (!rst_i && phase_o === 2'h3)
      begin
         check(mem_we_o, we_m);
         if (chk_a)
            check(mem_addr_o, addr_m);
         if (we_m)
            check(mem_wdata_o, res_m);
      end
      if (!rst_i && phase_o === 2'h0 && pend)
      begin
         check(done_o, 1'b1);
         check(illegal_o, ill_m);
         check(acc_o, acc_m);
         check(flags_o, flags_m);
         pend = 1'b0;
         retired++;
      end
      if (!rst_i && phase_o === 2'h0 && valid === 1'b1)
         decode(instr);
   end
   initial
   begin
      foreach (mem_m[i])
         mem_m[i] = 8'h00;
      rst_i = 1'b1;
      go = 1'b0;
      word = 16'h0000;
      ext_r = 1'b0;
      bank_r = 4'h0;
      base_r = 12'h000;
      acc_m = `ACL_ACC_RESET;
      flags_m = `ACL_FLAGS_RESET;
      pend = 1'b0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      go <= 1'b1;
      while (retired < 200)
         @(posedge clk_i);
      conclude();
   end
endmodule
bind acl_exec acl_exec_sva u_sva (.*);
`default_nettype wire
